//--- include/uef_regs.svh
`ifndef UEF_REGS_SVH
`define UEF_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UEF_STATUS_OFS 8'h00
`define UEF_ENABLE_OFS 8'h04
`define UEF_SUMMARY_OFS 8'h08
// ----------------------------------------
// Error status field positions
// ----------------------------------------
`define UEF_BIT_BITSTUFF 7
`define UEF_BIT_TURNAROUND 4
`define UEF_BIT_FIELD_SIZE 3
`define UEF_BIT_DATA_CRC 2
`define UEF_BIT_TOKEN_CRC 1
`define UEF_BIT_PID 0
// Implemented flag positions, bits 6-5 unused
`define UEF_FLAG_MASK 8'h9f
// ----------------------------------------
// Reset values
// ----------------------------------------
`define UEF_STATUS_RST 8'h00
`define UEF_ENABLE_RST 8'h00
// ----------------------------------------
// Timing and bus constants
// ----------------------------------------
// Idle bit times allowed after an end of packet
`define UEF_TURN_BITS 5'h10
`define UEF_CNT_ZERO 5'h00
`define UEF_CNT_ONE 5'h01
// Address bits decoded by the slave
`define UEF_ADDR_MSB 7
`endif

//--- include/uef_pkg.sv
// ----------------------------------------
// Shared types
// ----------------------------------------
package uef_pkg;
  // Turnaround watchdog states, Gray along the path
  typedef enum logic [1:0]
  {
    UEF_TA_IDLE = 2'b00,
    UEF_TA_COUNT = 2'b01,
    UEF_TA_FIRED = 2'b11
  } uef_ta_state_t;
endpackage

//--- design/uef_turnaround.sv
`include "uef_regs.svh"
// ----------------------------------------
// Bus turnaround time-out watchdog
// ----------------------------------------
module uef_turnaround
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic eop_i,
  input wire logic resp_wait_i,
  input wire logic bus_idle_i,
  input wire logic bit_tick_i,
  output logic timeout_o
);
  // State, idle bit counter, output pulse
  uef_pkg::uef_ta_state_t state_r;
  uef_pkg::uef_ta_state_t state_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic timeout_r;
  logic timeout_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    timeout_nxt = 1'b0;
    case (state_r)
      // Armed by an end of packet while a reply is due
      uef_pkg::UEF_TA_IDLE:
      begin
        if (eop_i && resp_wait_i)
        begin
          state_nxt = uef_pkg::UEF_TA_COUNT;
          cnt_nxt = `UEF_CNT_ZERO;
        end
      end
      // Counting idle bit times
      uef_pkg::UEF_TA_COUNT:
      begin
        if (!resp_wait_i || !bus_idle_i)
        begin
          state_nxt = uef_pkg::UEF_TA_IDLE;
        end
        else if (bit_tick_i)
        begin
          // RULE2: more than sixteen idle bits
          if (cnt_r == `UEF_TURN_BITS)
          begin
            state_nxt = uef_pkg::UEF_TA_FIRED;
            timeout_nxt = 1'b1;
          end
          else
          begin
            cnt_nxt = cnt_r + `UEF_CNT_ONE;
          end
        end
      end
      // One report per wait, then rest
      uef_pkg::UEF_TA_FIRED:
      begin
        if (!resp_wait_i)
        begin
          state_nxt = uef_pkg::UEF_TA_IDLE;
        end
      end
      default:
      begin
        state_nxt = uef_pkg::UEF_TA_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r <= uef_pkg::UEF_TA_IDLE;
      cnt_r <= `UEF_CNT_ZERO;
      timeout_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      timeout_r <= timeout_nxt;
    end
  end

  assign timeout_o = timeout_r;
endmodule

//--- design/uef_top.sv
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`include "uef_regs.svh"
// Function
// RULE1: Bit 7 flags bit-stuff violations
// RULE2: Bit 4 flags idle over sixteen bits
// RULE3: Bit 3 flags non-byte data field
// RULE4: Bit 2 data CRC, bit 1 token CRC
// RULE5: Bit 0 flags PID check failure
// RULE6: Flags readable, reset zero, bits 6-5 zero
// RULE7: Summary flag from enabled errors only
// RULE8: Writing zero clears, one keeps
module uef_top
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  // Size ignored, whole-word accesses assumed
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Error events from the receive path, one-cycle pulses
  input wire logic bitstuff_err_i,
  input wire logic field_size_err_i,
  input wire logic data_crc_fail_i,
  input wire logic token_crc_err_i,
  input wire logic pid_check_fail_i,
  // Turnaround watchdog inputs
  input wire logic eop_i,
  input wire logic resp_wait_i,
  input wire logic bus_idle_i,
  input wire logic bit_tick_i,
  // Summary error flag
  output logic usb_summary_err_flag_o
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  // Error status and enable registers
  logic [7:0] usb_error_status_r;
  logic [7:0] usb_error_status_nxt;
  logic [7:0] usb_error_enable_r;
  logic [7:0] usb_error_enable_nxt;
  // Summary flag
  logic usb_summary_err_flag_r;
  logic usb_summary_err_flag_nxt;
  // Captured write address phase
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  // Read data, prepared in the address phase
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic hreadyout_r;
  // Event vector in flag positions
  logic [7:0] event_vec;
  // One-cycle time-out pulse from the watchdog
  logic turnaround_timeout;
  // Qualified address phase
  logic addr_phase;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Address match on decoded byte offset
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // ----------------------------------------
  // Turnaround watchdog
  // ----------------------------------------
  // Counts idle bit times after an end of packet while a reply is due
  uef_turnaround u_turnaround
  (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .eop_i(eop_i),
    .resp_wait_i(resp_wait_i),
    .bus_idle_i(bus_idle_i),
    .bit_tick_i(bit_tick_i),
    .timeout_o(turnaround_timeout)
  );

  // ----------------------------------------
  // Event mapping
  // ----------------------------------------
  // Receive-path pulses land in their flag positions, bits 6-5 stay empty
  always_comb
  begin
    event_vec = 8'h00;
    // RULE1: bit-stuff into bit 7
    event_vec[`UEF_BIT_BITSTUFF] = bitstuff_err_i;
    // RULE2: time-out into bit 4
    event_vec[`UEF_BIT_TURNAROUND] = turnaround_timeout;
    // RULE3: field size into bit 3
    event_vec[`UEF_BIT_FIELD_SIZE] = field_size_err_i;
    // RULE4: CRC errors into bits 2, 1
    event_vec[`UEF_BIT_DATA_CRC] = data_crc_fail_i;
    event_vec[`UEF_BIT_TOKEN_CRC] = token_crc_err_i;
    // RULE5: PID check into bit 0
    event_vec[`UEF_BIT_PID] = pid_check_fail_i;
  end

  // ----------------------------------------
  // Bus phase tracking
  // ----------------------------------------
  // Zero wait states: an address phase taken on one edge has its data
  // phase complete on the next, so read data is prepared early.
  // Read data shows the flags at the address-phase edge; an event that
  // lands during the data phase shows on the following read.
  // Valid transfer accepted this cycle
  assign addr_phase = hsel_i && htrans_i[1] && hready_i;

  always_comb
  begin
    wr_pend_nxt = wr_pend_r;
    wr_addr_nxt = wr_addr_r;
    hrdata_nxt = hrdata_r;
    // Data phase finishes when the bus is ready
    if (hready_i)
    begin
      wr_pend_nxt = addr_phase && hwrite_i;
      wr_addr_nxt = haddr_i[`UEF_ADDR_MSB:0];
      hrdata_nxt = 32'h0000_0000;
      // Read data latched now, driven in the data phase
      if (addr_phase && !hwrite_i)
      begin
        // RULE6: unused bits read zero
        if (reg_hit(haddr_i[`UEF_ADDR_MSB:0], `UEF_STATUS_OFS))
        begin
          hrdata_nxt = {24'h00_0000, usb_error_status_r & `UEF_FLAG_MASK};
        end
        else if (reg_hit(haddr_i[`UEF_ADDR_MSB:0], `UEF_ENABLE_OFS))
        begin
          hrdata_nxt = {24'h00_0000, usb_error_enable_r & `UEF_FLAG_MASK};
        end
        else if (reg_hit(haddr_i[`UEF_ADDR_MSB:0], `UEF_SUMMARY_OFS))
        begin
          hrdata_nxt = {31'h0000_0000, usb_summary_err_flag_r};
        end
        // Unmapped reads return zero
        else
        begin
          hrdata_nxt = 32'h0000_0000;
        end
      end
    end
  end

  // ----------------------------------------
  // Register file next values
  // ----------------------------------------
  always_comb
  begin
    usb_error_status_nxt = usb_error_status_r;
    usb_error_enable_nxt = usb_error_enable_r;
    // Writes land at the end of the data phase, when hwdata is valid.
    // Status bits are clear-only: a one written keeps the flag, so
    // software cannot fake an error indication.
    // RULE8: zero written clears the flag
    if (wr_pend_r && reg_hit(wr_addr_r, `UEF_STATUS_OFS))
    begin
      usb_error_status_nxt = usb_error_status_r & hwdata_i[7:0];
    end
    // Enable register writable in flag positions, bits 6-5 held zero
    if (wr_pend_r && reg_hit(wr_addr_r, `UEF_ENABLE_OFS))
    begin
      usb_error_enable_nxt = hwdata_i[7:0] & `UEF_FLAG_MASK;
    end
    // An event in the same cycle as a clearing write still sets the
    // flag, so no error is lost to a read-modify-write race.
    // RULE6: set wins, unused bits held zero
    usb_error_status_nxt = (usb_error_status_nxt | event_vec) & `UEF_FLAG_MASK;
    // Summary follows the registered flags, one edge behind them
    // RULE7: only enabled flags raise summary
    usb_summary_err_flag_nxt = |(usb_error_status_r & usb_error_enable_r);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      // RULE6: flags zero at reset
      usb_error_status_r <= `UEF_STATUS_RST;
      usb_error_enable_r <= `UEF_ENABLE_RST;
      usb_summary_err_flag_r <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b0;
    end
    else
    begin
      usb_error_status_r <= usb_error_status_nxt;
      usb_error_enable_r <= usb_error_enable_nxt;
      usb_summary_err_flag_r <= usb_summary_err_flag_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      // Zero wait states once out of reset
      hreadyout_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Bus outputs come from registers, except the fixed OKAY response
  assign hreadyout_o = hreadyout_r;
  // Always OKAY
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_r;
  assign usb_summary_err_flag_o = usb_summary_err_flag_r;
endmodule

//--- bench/uef_flags_checker.sv
module uef_flags_checker
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic bitstuff_err_i,
  input wire logic field_size_err_i,
  input wire logic data_crc_fail_i,
  input wire logic token_crc_err_i,
  input wire logic pid_check_fail_i,
  input wire logic bit_tick_i,
  input wire logic usb_summary_err_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bus and flag properties
  // ----------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Transfer taken, and write taken
  wire logic tk = hsel_i & htrans_i[1] & hready_i;
  wire logic wr = tk & hwrite_i;
  // Any error pulse from the receive path
  wire logic ev = bitstuff_err_i | field_size_err_i | data_crc_fail_i
    | token_crc_err_i | pid_check_fail_i;
  bus_okay_a: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  bus_ready_a: assert property (!$past(reset_i) |-> hreadyout_o)
    else $error("slave stalled");
  idle_data_a: assert property (!tk |=> hrdata_o == 32'h0)
    else $error("read data outside data phase");
  upper_zero_a: assert property (tk && !hwrite_i |=> hrdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  unused_zero_a: assert property (tk && !hwrite_i && haddr_i[7:0] == 8'h00 |=>
    hrdata_o[6:5] == 2'h0) else $error("unused status bits set");
  summary_bits_a: assert property (tk && !hwrite_i && haddr_i[7:0] == 8'h08 |=>
    hrdata_o[31:1] == 31'h0) else $error("summary word has extra bits");
  summary_rise_a: assert property ($rose(usb_summary_err_flag_o) |->
    $past(ev, 2) || $past(bit_tick_i, 3) || $past(wr, 3)) else $error("summary rose alone");
  summary_fall_a: assert property ($fell(usb_summary_err_flag_o) |-> $past(wr, 3))
    else $error("summary fell without write");
endmodule

//--- bench/uef_host_model.sv
// ----------------------------------------
// Host side: faulty packets, silent bus
// ----------------------------------------
module uef_host_model
(
  input wire logic sys_clk_i,
  output logic [4:0] err_o,
  output logic eop_o,
  output logic wait_o,
  output logic idle_o,
  output logic tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {err_o, eop_o, wait_o, idle_o, tick_o} = '0;
  // One faulty packet, one-cycle pulse
  // error events
  task automatic bad_pkt(input logic [4:0] e);
    @(posedge sys_clk_i) err_o <= e;
    @(posedge sys_clk_i) err_o <= 5'h00;
  endtask
  // Host stays silent for n bit times
  // idle after packet
  task automatic silent(input int n);
    @(posedge sys_clk_i) {eop_o, wait_o, idle_o} <= 3'h7;
    @(posedge sys_clk_i) eop_o <= 1'b0;
    repeat (n)
    begin
      @(posedge sys_clk_i) tick_o <= 1'b1;
      @(posedge sys_clk_i) tick_o <= 1'b0;
    end
    repeat (3) @(posedge sys_clk_i);
    {wait_o, idle_o} <= 2'h0;
  endtask
endmodule

//--- bench/uef_tb_top.sv
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch %0t got %h", $time, a); end end
module usb_error_status_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o, rd;
  logic hreadyout_o, hresp_o, sum_o, eop, wt, idl, tick;
  logic [4:0] err;
  logic [7:0] pos [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h80};
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  initial forever #2 sys_clk_i = ~sys_clk_i;
  uef_host_model host (.sys_clk_i(sys_clk_i), .err_o(err), .eop_o(eop),
    .wait_o(wt), .idle_o(idl), .tick_o(tick));
  uef_top uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .hrdata_o(hrdata_o), .bitstuff_err_i(err[4]),
    .field_size_err_i(err[3]), .data_crc_fail_i(err[2]), .token_crc_err_i(err[1]),
    .pid_check_fail_i(err[0]), .eop_i(eop), .resp_wait_i(wt), .bus_idle_i(idl),
    .bit_tick_i(tick), .usb_summary_err_flag_o(sum_o));
  // Single bus transfer, address then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    {hsel_i, htrans_i, hwrite_i, haddr_i} <= {1'b1, 2'h2, w, 24'h0, a};
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    {hsel_i, htrans_i, hwdata_i} <= {1'b0, 2'h0, d};
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      host.bad_pkt(5'h01 << i);
      rchk(8'h00, {24'h0, pos[i]});
      xfer(1'b1, 8'h00, 32'h0);
      rchk(8'h00, 32'h0);
    end
    host.bad_pkt(5'h1f);
    xfer(1'b1, 8'h00, 32'hff);
    rchk(8'h00, 32'h8f);
    xfer(1'b1, 8'h00, 32'h7f);
    xfer(1'b1, 8'h04, 32'hff);
    rchk(8'h04, 32'h9f);
    rchk(8'h00, 32'h0f);
    rchk(8'h08, 32'h1);
    `CHK(sum_o, 1'b1)
    xfer(1'b1, 8'h04, 32'h10);
    rchk(8'h08, 32'h0);
    xfer(1'b1, 8'h00, 32'h0);
    host.silent(16);
    rchk(8'h00, 32'h0);
    host.silent(17);
    rchk(8'h00, 32'h10);
    rchk(8'h08, 32'h1);
    `CHK(sum_o, 1'b1)
    xfer(1'b1, 8'h00, 32'h0);
    rchk(8'h08, 32'h0);
    `CHK(sum_o, 1'b0)
    xfer(1'b1, 8'h40, 32'hff);
    rchk(8'h40, 32'h0);
    end_of_test();
  end
endmodule
bind uef_top uef_flags_checker chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .hrdata_o(hrdata_o), .bitstuff_err_i(bitstuff_err_i),
  .field_size_err_i(field_size_err_i), .data_crc_fail_i(data_crc_fail_i),
  .token_crc_err_i(token_crc_err_i), .pid_check_fail_i(pid_check_fail_i),
  .bit_tick_i(bit_tick_i), .usb_summary_err_flag_o(usb_summary_err_flag_o));
